// ### rtl/sgpic_pkg.sv
// Shared constants, enumerations and carrier structs for the poll/IFC unit
package sgpic_pkg;

  // Command opcodes
  localparam logic [7:0] OP_SERIAL_POLL = 8'hd3;
  localparam logic [7:0] OP_SET_RESPONSE = 8'hd4;
  localparam logic [7:0] OP_IFC = 8'hd5;

  // Field positions inside the command bytes
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 3;
  localparam int MODE_BIT = 2;
  localparam int RQS_BIT = 6;
  localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1;

  // Sense keys
  localparam logic [3:0] SENSE_NONE = 4'h0;
  localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
  localparam logic [3:0] SENSE_ERROR = 4'h9;

  // Status and message bytes
  localparam logic [7:0] STATUS_GOOD = 8'h00;
  localparam logic [7:0] STATUS_CHECK = 8'h02;
  localparam logic [7:0] MSG_COMPLETE = 8'h00;
  localparam logic [7:0] POLL_NO_ANSWER = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned IFC_TIME_US = 500;
  localparam int unsigned IFC_MIN_US = 100;
  localparam int unsigned POLL_LIMIT_MS = 100;
  localparam int unsigned IFC_CYCLES = IFC_TIME_US * CLK_MHZ;
  localparam int unsigned IFC_MIN_CYCLES = IFC_MIN_US * CLK_MHZ;
  localparam int unsigned POLL_CYCLES = POLL_LIMIT_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  typedef enum logic [2:0] {
    PH_BUS_FREE,
    PH_COMMAND,
    PH_DATA_IN,
    PH_STATUS,
    PH_MSG_IN
  } sgpic_phase_t;

  typedef enum logic [1:0] {
    ERR_NONE,
    BUS_ABORT_ERROR,
    NOT_SYSTEM_CONTROLLER_ERROR
  } sgpic_err_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_IFC,
    ST_POLL,
    ST_DATA,
    ST_STATUS,
    ST_MSG
  } sgpic_fsm_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [7:0] byte3;
    logic [7:0] byte4;
    logic [7:0] byte5;
  } sgpic_cdb_t;

  typedef struct packed {
    logic              req;
    logic [ADDR_W-1:0] primary;
    logic [ADDR_W-1:0] secondary;
    logic              secValid;
  } sgpic_poll_t;

  typedef struct packed {
    sgpic_fsm_t       fsm;
    sgpic_phase_t     phase;
    sgpic_cdb_t       cdb;
    logic [7:0]       xferByte;
    logic             xferValid;
    sgpic_poll_t      poll;
    logic             ifc;
    logic             ren;
    logic             srq;
    logic             cic;
    logic             sysCtl;
    logic             firstDone;
    logic             autoIfc;
    logic             checkCond;
    logic [3:0]       senseKey;
    sgpic_err_t       errCode;
    logic [7:0]       spResp;
    logic [7:0]       spOut;
    logic [7:0]       pollResult;
    logic             extPollLast;
    logic [CNT_W-1:0] cnt;
    logic             busy;
  } sgpic_state_t;

endpackage : sgpic_pkg

// ### rtl/sgpic_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module sgpic_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sgpic_sync_st_t;

  sgpic_sync_st_t syncReg;
  sgpic_sync_st_t syncNext;

  always_comb begin
    syncNext = syncReg;
    syncNext.s1 = pinIn;
    syncNext.s2 = syncReg.s1;
    syncNext.s3 = syncReg.s2;
    // Only accept a level that held for two stages
    if (syncReg.s2 == syncReg.s3) begin
      syncNext.q = syncReg.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign syncOut = syncReg.q;

endmodule : sgpic_sync

// ### rtl/sgpic_cmd.sv
// Serial poll, poll response and interface clear command sequencer
//
// Overview of operation
// - Opcode D3 polls; byte1 7..3 primary, byte2 7..3 secondary, bit2 mode.
// - Secondary address is used only when the mode flag is one.
// - Poll the instrument and capture its status byte unaltered.
// - No answer within 1/10 s gives result FF and bus abort error.
// - Poll timeout also aborts with CHECK CONDITION and sense key error.
// - A completed poll returns exactly one byte in Data In.
// - First controller command with system control pulses IFC, then REN; code sets REN only after the automatic IFC of a D3 poll, not after D5.
// - Not controller-in-charge: abort poll, CHECK CONDITION, sense error.
// - Mode zero with nonzero secondary: abort, CHECK, illegal request.
// - Poll steps Command, Data In, Status, Message In phases.
// - Opcode D4 stores byte3 as the new poll response byte.
// - Return stored byte when polled externally; SRQ follows its bit 6.
// - Set response and IFC commands use Command, Status, Message In.
// - Opcode D5 drives IFC for 500 us and gives controller-in-charge.
// - The IFC pulse never lasts less than 100 us.
// - IFC without system control: error record, CHECK, sense error.
// - System control mode 1 takes, mode 0 releases; held after reset.
// - Sense key 5 is illegal request, 9 is general error.
`timescale 1ns/1ps
module sgpic_cmd #(
  parameter int unsigned IFC_LEN     = sgpic_pkg::IFC_CYCLES,
  parameter int unsigned IFC_MIN_LEN = sgpic_pkg::IFC_MIN_CYCLES,
  parameter int unsigned POLL_LEN    = sgpic_pkg::POLL_CYCLES
) (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic                              cmdValid,
  input  wire sgpic_pkg::sgpic_cdb_t             cmdBlock,
  input  wire logic                              byteTaken,
  input  wire logic                              pollDone,
  input  wire logic [7:0]                        pollByte,
  input  wire logic                              sysCtlWrite,
  input  wire logic                              sysCtlMode,
  input  wire logic                              ctlPassed,
  input  wire logic                              extPollPin,
  output sgpic_pkg::sgpic_phase_t                busPhase,
  output logic [7:0]                             xferByte,
  output logic                                   xferValid,
  output sgpic_pkg::sgpic_poll_t                 pollCtl,
  output logic                                   ifcActive,
  output logic                                   renActive,
  output logic                                   srqActive,
  output logic                                   cicActive,
  output logic                                   sysCtlActive,
  output logic [3:0]                             senseKey,
  output sgpic_pkg::sgpic_err_t                  errorCode,
  output logic [7:0]                             spByteOut,
  output logic [7:0]                             pollResult,
  output logic                                   cmdBusy
);

  // Never let a short setting cut the pulse below the bus minimum
  localparam int unsigned IFC_EFF =
    (IFC_LEN < IFC_MIN_LEN) ? IFC_MIN_LEN : IFC_LEN;
  localparam logic [sgpic_pkg::CNT_W-1:0] IFC_LAST =
    sgpic_pkg::CNT_W'(IFC_EFF - 1);
  localparam logic [sgpic_pkg::CNT_W-1:0] POLL_LAST =
    sgpic_pkg::CNT_W'(POLL_LEN - 1);

  sgpic_pkg::sgpic_state_t stateReg;
  sgpic_pkg::sgpic_state_t stateNext;
  logic                    extPollSync;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser for another controller polling us

  sgpic_sync #(
    .W (1)
  ) u_ext_poll_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .pinIn   (extPollPin),
    .syncOut (extPollSync)
  );

  //////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic sgpic_pkg::sgpic_state_t startPoll(
    input sgpic_pkg::sgpic_state_t st
  );
    sgpic_pkg::sgpic_state_t r;
    r = st;
    r.poll.req = 1'b1;
    r.poll.primary =
      st.cdb.byte1[sgpic_pkg::ADDR_MSB:sgpic_pkg::ADDR_LSB];
    r.poll.secValid = st.cdb.byte2[sgpic_pkg::MODE_BIT];
    r.poll.secondary = st.cdb.byte2[sgpic_pkg::MODE_BIT] ?
      st.cdb.byte2[sgpic_pkg::ADDR_MSB:sgpic_pkg::ADDR_LSB] :
      '0;
    r.cnt = sgpic_pkg::CNT_ZERO;
    r.fsm = sgpic_pkg::ST_POLL;
    return r;
  endfunction : startPoll

  function automatic sgpic_pkg::sgpic_state_t failCmd(
    input sgpic_pkg::sgpic_state_t st,
    input logic [3:0]              key
  );
    sgpic_pkg::sgpic_state_t r;
    r = st;
    r.checkCond = 1'b1;
    r.senseKey = key;
    r.fsm = sgpic_pkg::ST_STATUS;
    return r;
  endfunction : failCmd

  function automatic sgpic_pkg::sgpic_state_t startIfc(
    input sgpic_pkg::sgpic_state_t st,
    input logic                    isAuto
  );
    sgpic_pkg::sgpic_state_t r;
    r = st;
    r.ifc = 1'b1;
    r.autoIfc = isAuto;
    r.cnt = sgpic_pkg::CNT_ZERO;
    r.fsm = sgpic_pkg::ST_IFC;
    return r;
  endfunction : startIfc

  //////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    stateNext = stateReg;
    stateNext.extPollLast = extPollSync;
    stateNext.srq = stateReg.spResp[sgpic_pkg::RQS_BIT];
    if (extPollSync && !stateReg.extPollLast) begin
      stateNext.spOut = stateReg.spResp;
    end
    if (sysCtlWrite) begin
      stateNext.sysCtl = sysCtlMode;
    end
    // Passing control away only drops the controller role
    if (ctlPassed) begin
      stateNext.cic = 1'b0;
    end

    case (stateReg.fsm)
      sgpic_pkg::ST_IDLE: begin
        stateNext.phase = sgpic_pkg::PH_BUS_FREE;
        if (cmdValid) begin
          stateNext.cdb = cmdBlock;
          stateNext.phase = sgpic_pkg::PH_COMMAND;
          stateNext.fsm = sgpic_pkg::ST_DECODE;
          stateNext.busy = 1'b1;
        end
      end

      sgpic_pkg::ST_DECODE: begin
        stateNext.checkCond = 1'b0;
        stateNext.senseKey = sgpic_pkg::SENSE_NONE;
        stateNext.errCode = sgpic_pkg::ERR_NONE;
        case (stateReg.cdb.opcode)
          sgpic_pkg::OP_SERIAL_POLL: begin
            if (!stateReg.cdb.byte2[sgpic_pkg::MODE_BIT] &&
                (stateReg.cdb.byte2[sgpic_pkg::ADDR_MSB:sgpic_pkg::ADDR_LSB]
                 != '0)) begin
              stateNext = failCmd(stateNext,
                                  sgpic_pkg::SENSE_ILLEGAL);
            end else if (stateReg.cic) begin
              stateNext = startPoll(stateNext);
            end else if (stateReg.sysCtl && !stateReg.firstDone) begin
              stateNext = startIfc(stateNext, 1'b1);
            end else begin
              stateNext = failCmd(stateNext, sgpic_pkg::SENSE_ERROR);
            end
          end
          sgpic_pkg::OP_SET_RESPONSE: begin
            stateNext.spResp = stateReg.cdb.byte3;
            stateNext.fsm = sgpic_pkg::ST_STATUS;
          end
          sgpic_pkg::OP_IFC: begin
            if (stateReg.sysCtl) begin
              stateNext = startIfc(stateNext, 1'b0);
            end else begin
              stateNext.errCode =
                sgpic_pkg::NOT_SYSTEM_CONTROLLER_ERROR;
              stateNext = failCmd(stateNext, sgpic_pkg::SENSE_ERROR);
            end
          end
          default: begin
            stateNext = failCmd(stateNext, sgpic_pkg::SENSE_ILLEGAL);
          end
        endcase
      end

      sgpic_pkg::ST_IFC: begin
        stateNext.cnt = stateReg.cnt + sgpic_pkg::CNT_ONE;
        if (stateReg.cnt == IFC_LAST) begin
          stateNext.ifc = 1'b0;
          stateNext.cic = 1'b1;
          stateNext.firstDone = 1'b1;
          stateNext.cnt = sgpic_pkg::CNT_ZERO;
          if (stateReg.autoIfc) begin
            stateNext.ren = 1'b1;
            stateNext = startPoll(stateNext);
          end else begin
            stateNext.fsm = sgpic_pkg::ST_STATUS;
          end
        end
      end

      sgpic_pkg::ST_POLL: begin
        stateNext.cnt = stateReg.cnt + sgpic_pkg::CNT_ONE;
        // An answer in the limit cycle still counts as an answer
        if (pollDone) begin
          stateNext.poll.req = 1'b0;
          stateNext.pollResult = pollByte;
          stateNext.fsm = sgpic_pkg::ST_DATA;
        end else if (stateReg.cnt == POLL_LAST) begin
          stateNext.poll.req = 1'b0;
          stateNext.pollResult = sgpic_pkg::POLL_NO_ANSWER;
          stateNext.errCode = sgpic_pkg::BUS_ABORT_ERROR;
          stateNext = failCmd(stateNext, sgpic_pkg::SENSE_ERROR);
        end
      end

      sgpic_pkg::ST_DATA: begin
        stateNext.phase = sgpic_pkg::PH_DATA_IN;
        stateNext.xferByte = stateReg.pollResult;
        stateNext.xferValid = 1'b1;
        if (stateReg.xferValid && byteTaken) begin
          stateNext.xferValid = 1'b0;
          stateNext.fsm = sgpic_pkg::ST_STATUS;
        end
      end

      sgpic_pkg::ST_STATUS: begin
        stateNext.phase = sgpic_pkg::PH_STATUS;
        stateNext.xferByte = stateReg.checkCond ?
          sgpic_pkg::STATUS_CHECK : sgpic_pkg::STATUS_GOOD;
        stateNext.xferValid = 1'b1;
        if (stateReg.xferValid && byteTaken &&
            stateReg.phase == sgpic_pkg::PH_STATUS) begin
          stateNext.xferValid = 1'b0;
          stateNext.fsm = sgpic_pkg::ST_MSG;
        end
      end

      sgpic_pkg::ST_MSG: begin
        stateNext.phase = sgpic_pkg::PH_MSG_IN;
        stateNext.xferByte = sgpic_pkg::MSG_COMPLETE;
        stateNext.xferValid = 1'b1;
        if (stateReg.xferValid && byteTaken &&
            stateReg.phase == sgpic_pkg::PH_MSG_IN) begin
          stateNext.xferValid = 1'b0;
          stateNext.phase = sgpic_pkg::PH_BUS_FREE;
          stateNext.fsm = sgpic_pkg::ST_IDLE;
          stateNext.busy = 1'b0;
        end
      end

      default: begin
        stateNext.fsm = sgpic_pkg::ST_IDLE;
        stateNext.busy = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stateReg <= '0;
      stateReg.fsm <= sgpic_pkg::ST_IDLE;
      stateReg.phase <= sgpic_pkg::PH_BUS_FREE;
      stateReg.errCode <= sgpic_pkg::ERR_NONE;
      stateReg.sysCtl <= 1'b1;
      stateReg.pollResult <= sgpic_pkg::BYTE_ZERO;
    end else begin
      stateReg <= stateNext;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign busPhase = stateReg.phase;
  assign xferByte = stateReg.xferByte;
  assign xferValid = stateReg.xferValid;
  assign pollCtl = stateReg.poll;
  assign ifcActive = stateReg.ifc;
  assign renActive = stateReg.ren;
  assign srqActive = stateReg.srq;
  assign cicActive = stateReg.cic;
  assign sysCtlActive = stateReg.sysCtl;
  assign senseKey = stateReg.senseKey;
  assign errorCode = stateReg.errCode;
  assign spByteOut = stateReg.spOut;
  assign pollResult = stateReg.pollResult;
  // Busy is its own flop so the port carries no decode glitches
  assign cmdBusy = stateReg.busy;

endmodule : sgpic_cmd

// ### dv/sgpic_cmd_asserts.sv
// Port-level checks for the poll/IFC command sequencer
`timescale 1ns/1ps
module sgpic_cmd_asserts #(
  parameter int unsigned IFC_LEN     = 20,
  parameter int unsigned IFC_MIN_LEN = 10,
  parameter int unsigned POLL_LEN    = 50
) (
  input wire logic                    clk,
  input wire logic                    rst_b,
  input wire logic                    cmdValid,
  input wire logic                    cmdBusy,
  input wire logic                    byteTaken,
  input wire logic                    pollDone,
  input wire logic                    sysCtlWrite,
  input wire logic                    sysCtlMode,
  input wire logic                    ctlPassed,
  input wire sgpic_pkg::sgpic_phase_t busPhase,
  input wire logic [7:0]              xferByte,
  input wire logic                    xferValid,
  input wire sgpic_pkg::sgpic_poll_t  pollCtl,
  input wire logic                    ifcActive,
  input wire logic                    renActive,
  input wire logic                    srqActive,
  input wire logic                    cicActive,
  input wire logic                    sysCtlActive,
  input wire logic [3:0]              senseKey,
  input wire sgpic_pkg::sgpic_err_t   errorCode,
  input wire logic [7:0]              spByteOut,
  input wire logic [7:0]              pollResult
);
  localparam int unsigned IFC_EXP = (IFC_LEN > IFC_MIN_LEN) ? IFC_LEN
                                                              : IFC_MIN_LEN;
  logic [31:0] ifcRun_reg;
  logic [31:0] reqRun_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Run lengths of the IFC pulse and of the poll request
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ifcRun_reg <= 32'h0;
      reqRun_reg <= 32'h0;
    end else begin
      ifcRun_reg <= ifcActive ? ifcRun_reg + 32'h1 : 32'h0;
      reqRun_reg <= pollCtl.req ? reqRun_reg + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_CMD_PHASE: assert property (cmdValid && !cmdBusy |=>
    busPhase == sgpic_pkg::PH_COMMAND) else $error("no command phase");
  AST_IFC_LEN: assert property ($fell(ifcActive) |->
    ifcRun_reg == IFC_EXP && cicActive) else $error("IFC length wrong");
  AST_IFC_MIN: assert property ($fell(ifcActive) |->
    ifcRun_reg >= IFC_MIN_LEN) else $error("IFC too short");
  AST_REN_AUTO: assert property ($rose(renActive) |->
    $fell(ifcActive) && cicActive) else $error("REN before IFC end");
  AST_POLL_LIMIT: assert property (pollCtl.req |->
    reqRun_reg < POLL_LEN) else $error("poll request too long");
  AST_TIMEOUT_FF: assert property (
    $fell(pollCtl.req) && !$past(pollDone) |->
    ##[0:2] (pollResult == sgpic_pkg::POLL_NO_ANSWER &&
    errorCode == sgpic_pkg::BUS_ABORT_ERROR)) else $error("timeout result");
  AST_SEC_MODE: assert property (pollCtl.req && !pollCtl.secValid |->
    pollCtl.secondary == 5'h00) else $error("secondary used in mode 0");
  AST_STATUS_BYTE: assert property (
    busPhase == sgpic_pkg::PH_STATUS && xferValid |-> xferByte ==
    (senseKey == sgpic_pkg::SENSE_NONE ? sgpic_pkg::STATUS_GOOD
     : sgpic_pkg::STATUS_CHECK)) else $error("status byte wrong");
  AST_MSG_BYTE: assert property (
    busPhase == sgpic_pkg::PH_MSG_IN && xferValid |->
    xferByte == sgpic_pkg::MSG_COMPLETE) else $error("message byte wrong");
  AST_DATA_ONE: assert property (
    busPhase == sgpic_pkg::PH_DATA_IN && xferValid && byteTaken |=>
    !xferValid ##1 (busPhase == sgpic_pkg::PH_STATUS && xferValid))
    else $error("data phase not one byte");
  AST_DATA_BYTE: assert property (
    busPhase == sgpic_pkg::PH_DATA_IN && xferValid |->
    xferByte == pollResult) else $error("data byte wrong");
  AST_SYSCTL: assert property (sysCtlWrite |=>
    sysCtlActive == $past(sysCtlMode)) else $error("system control");
  AST_CIC_PASS: assert property (ctlPassed && !ifcActive |=>
    !cicActive) else $error("still in charge");
  AST_SRQ: assert property ($changed(spByteOut) |->
    srqActive == spByteOut[sgpic_pkg::RQS_BIT]) else $error("SRQ level");
endmodule : sgpic_cmd_asserts

bind sgpic_cmd sgpic_cmd_asserts #(.IFC_LEN(IFC_LEN),
  .IFC_MIN_LEN(IFC_MIN_LEN), .POLL_LEN(POLL_LEN)) chk (.clk(clk),
  .rst_b(rst_b), .cmdValid(cmdValid), .cmdBusy(cmdBusy),
  .byteTaken(byteTaken), .pollDone(pollDone), .sysCtlWrite(sysCtlWrite),
  .sysCtlMode(sysCtlMode), .ctlPassed(ctlPassed), .busPhase(busPhase),
  .xferByte(xferByte), .xferValid(xferValid), .pollCtl(pollCtl),
  .ifcActive(ifcActive), .renActive(renActive), .srqActive(srqActive),
  .cicActive(cicActive), .sysCtlActive(sysCtlActive), .senseKey(senseKey),
  .errorCode(errorCode), .spByteOut(spByteOut), .pollResult(pollResult));

// ### dv/sgpic_partner.sv
// Far side: initiator taking bytes and an instrument answering polls
`timescale 1ns/1ps
module sgpic_partner (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       xferValid,
  input  wire logic       pollReq,
  input  wire logic [7:0] takeDelay,
  input  wire logic [7:0] answerDelay,
  input  wire logic       answerMute,
  input  wire logic [7:0] answerByte,
  output logic            byteTaken,
  output logic            pollDone,
  output logic      [7:0] pollByte
);
  logic [7:0] takeCnt;
  logic [7:0] pollCnt;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      byteTaken <= 1'b0;
      pollDone  <= 1'b0;
      takeCnt   <= 8'h00;
      pollCnt   <= 8'h00;
      pollByte  <= 8'h00;
    end else begin
      byteTaken <= 1'b0;
      takeCnt   <= (xferValid && !byteTaken) ? takeCnt + 8'h01 : 8'h00;
      if (xferValid && !byteTaken && takeCnt >= takeDelay)
        byteTaken <= 1'b1;
      // Byte wanders outside the strobe so stale data cannot match
      pollDone <= 1'b0;
      pollByte <= ~answerByte;
      pollCnt  <= (pollReq && !pollDone) ? pollCnt + 8'h01 : 8'h00;
      if (pollReq && !pollDone && !answerMute && pollCnt >= answerDelay) begin
        pollDone <= 1'b1;
        pollByte <= answerByte;
      end
    end
  end
endmodule : sgpic_partner

// ### dv/sgpic_cmd_test.sv
// Directed bench for the poll/IFC command sequencer
`timescale 1ns/1ps
module sgpic_cmd_test;
  logic clk, rst_b, cmdValid, byteTaken, pollDone, sysCtlWrite, sysCtlMode;
  logic ctlPassed, extPollPin, xferValid, ifcActive, renActive, srqActive;
  logic cicActive, sysCtlActive, cmdBusy, answerMute;
  logic [7:0] pollByte, xferByte, spByteOut, pollResult, answerByte, ifcCnt;
  logic [7:0] statByte, msgByte, dataByte, dataCnt, takeDelay, answerDelay;
  logic [3:0] senseKey;
  sgpic_pkg::sgpic_cdb_t   cmdBlock;
  sgpic_pkg::sgpic_phase_t busPhase;
  sgpic_pkg::sgpic_poll_t  pollCtl, pollSeen;
  sgpic_pkg::sgpic_err_t   errorCode;
  int err_count, total_checks, cyc;
  localparam logic [7:0] GOOD  = sgpic_pkg::STATUS_GOOD;
  localparam logic [7:0] CHECK = sgpic_pkg::STATUS_CHECK;

  sgpic_cmd #(.IFC_LEN(20), .IFC_MIN_LEN(10), .POLL_LEN(50)) uut (
    .clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdBlock(cmdBlock),
    .byteTaken(byteTaken), .pollDone(pollDone), .pollByte(pollByte),
    .sysCtlWrite(sysCtlWrite), .sysCtlMode(sysCtlMode),
    .ctlPassed(ctlPassed), .extPollPin(extPollPin), .busPhase(busPhase),
    .xferByte(xferByte), .xferValid(xferValid), .pollCtl(pollCtl),
    .ifcActive(ifcActive), .renActive(renActive), .srqActive(srqActive),
    .cicActive(cicActive), .sysCtlActive(sysCtlActive),
    .senseKey(senseKey), .errorCode(errorCode), .spByteOut(spByteOut),
    .pollResult(pollResult), .cmdBusy(cmdBusy));
  sgpic_partner far (.clk(clk), .rst_b(rst_b), .xferValid(xferValid),
    .pollReq(pollCtl.req), .takeDelay(takeDelay), .answerDelay(answerDelay),
    .answerMute(answerMute), .answerByte(answerByte), .byteTaken(byteTaken),
    .pollDone(pollDone), .pollByte(pollByte));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog and capture of every byte the initiator takes
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("Error %0t: run hung", $time);
      close_out();
    end
    if (pollCtl.req) pollSeen = pollCtl;
    if (ifcActive) ifcCnt++;
    if (xferValid && byteTaken) begin
      case (busPhase)
        sgpic_pkg::PH_DATA_IN: begin
          dataCnt++;
          dataByte = xferByte;
        end
        sgpic_pkg::PH_STATUS: statByte = xferByte;
        sgpic_pkg::PH_MSG_IN: msgByte = xferByte;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic flag(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : flag

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (6) tick();
    rst_b = 1'b1;
    repeat (3) tick();
  endtask : do_reset

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask : pulse

  // One whole command; checks status, message and Data In count
  task automatic cmd(input logic [7:0] op, b1, b2, b3, st, nd, dat);
    int n;
    n = 0;
    dataCnt = 8'h00;
    ifcCnt = 8'h00;
    statByte = 8'hxx;
    msgByte = 8'hxx;
    cmdBlock = {op, b1, b2, b3, 16'h0000};
    cmdValid = 1'b1;
    tick();
    cmdValid = 1'b0;
    do begin
      tick();
      n++;
    end while ((cmdBusy !== 1'b0 || busPhase !== sgpic_pkg::PH_BUS_FREE)
               && n < 400);
    chk(statByte, st);
    chk(msgByte, sgpic_pkg::MSG_COMPLETE);
    chk(dataCnt, nd);
    if (nd != 8'h00) chk(dataByte, dat);
  endtask : cmd

  task automatic close_out();
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, cmdValid, sysCtlWrite, sysCtlMode, ctlPassed} = 5'h00;
    {extPollPin, answerMute} = 2'h0;
    cmdBlock = 48'h0;
    {takeDelay, answerDelay, answerByte} = 24'h00_02_46;
    {err_count, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    dataCnt = 8'h00;
    do_reset();
    flag(sysCtlActive, 1'b1);
    cmd(8'hd3, 8'h18, 8'h50, 8'h00, CHECK, 8'h00, 8'h00);
    chk({4'h0, senseKey}, 8'h05);
    flag(cicActive, 1'b0);
    cmd(8'hd3, 8'h18, 8'h00, 8'hff, GOOD, 8'h01, 8'h46);
    chk(ifcCnt, 8'h14);
    chk({6'h00, renActive, cicActive}, 8'h03);
    chk({3'h0, pollSeen.primary}, 8'h03);
    {takeDelay, answerDelay, answerByte} = 24'h03_09_81;
    cmd(8'hd3, 8'h18, 8'h54, 8'h00, GOOD, 8'h01, 8'h81);
    chk({pollSeen.secValid, 2'h0, pollSeen.secondary}, 8'h8a);
    answerMute = 1'b1;
    cmd(8'hd3, 8'h18, 8'h00, 8'h00, CHECK, 8'h00, 8'h00);
    chk(pollResult, 8'hff);
    chk({4'h0, senseKey}, 8'h09);
    chk({6'h00, errorCode}, {6'h00, sgpic_pkg::BUS_ABORT_ERROR});
    answerMute = 1'b0;
    cmd(8'hd4, 8'h00, 8'h00, 8'h46, GOOD, 8'h00, 8'h00);
    chk({6'h00, errorCode}, {6'h00, sgpic_pkg::ERR_NONE});
    flag(srqActive, 1'b1);
    extPollPin = 1'b1;
    repeat (8) tick();
    extPollPin = 1'b0;
    chk(spByteOut, 8'h46);
    cmd(8'hd4, 8'h00, 8'h00, 8'h35, GOOD, 8'h00, 8'h00);
    extPollPin = 1'b1;
    repeat (8) tick();
    extPollPin = 1'b0;
    chk(spByteOut, 8'h35);
    flag(srqActive, 1'b0);
    pulse(ctlPassed);
    flag(cicActive, 1'b0);
    cmd(8'hd3, 8'h18, 8'h00, 8'h00, CHECK, 8'h00, 8'h00);
    chk({4'h0, senseKey}, 8'h09);
    cmd(8'hd5, 8'h00, 8'hff, 8'hff, GOOD, 8'h00, 8'h00);
    chk(ifcCnt, 8'h14);
    flag(cicActive, 1'b1);
    cmd(8'hd0, 8'h00, 8'h00, 8'h00, CHECK, 8'h00, 8'h00);
    chk({4'h0, senseKey}, 8'h05);
    pulse(sysCtlWrite);
    flag(sysCtlActive, 1'b0);
    cmd(8'hd5, 8'h00, 8'h00, 8'h00, CHECK, 8'h00, 8'h00);
    chk({4'h0, senseKey}, 8'h09);
    chk(ifcCnt, 8'h00);
    chk({6'h00, errorCode},
        {6'h00, sgpic_pkg::NOT_SYSTEM_CONTROLLER_ERROR});
    sysCtlMode = 1'b1;
    pulse(sysCtlWrite);
    flag(sysCtlActive, 1'b1);
    sysCtlMode = 1'b0;
    pulse(sysCtlWrite);
    do_reset();
    flag(sysCtlActive, 1'b1);
    close_out();
  end
endmodule : sgpic_cmd_test
